// *** hw/pwm_time_base_pkg.sv ***
// Shared constants for the pulse time base and output control block
package pwm_time_base_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_COUNT    = 8'h04;
  localparam logic [7:0]  OFS_PERIOD   = 8'h08;
  localparam logic [7:0]  OFS_PIN_CTRL = 8'h0c;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_CONFIG   = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_OPS_LSB    = 4;
  localparam int CTL_CKPS_LSB   = 2;
  localparam int CTL_MODE_LSB   = 0;
  localparam int COUNT_DIR_BIT  = 15;
  localparam int CFG_OWNER_BIT  = 2;
  localparam int CFG_HIGH_SIDE_POLARITY_BIT   = 1;
  localparam int CFG_LOW_SIDE_POLARITY_BIT   = 0;
  localparam int STATUS_IRQ_BIT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [14:0] COUNT_RESET   = 15'h0000;
  localparam logic [14:0] PERIOD_RESET  = 15'h0000;
  localparam logic [3:0]  POST_RESET    = 4'h0;
  localparam logic [5:0]  PRE_RESET     = 6'h00;
  localparam logic [2:0]  CONFIG_RESET  = 3'h7;
  localparam logic [7:0]  PIN_EN_ALL    = 8'hff;
  localparam logic [7:0]  PIN_EN_NONE   = 8'h00;

  // ****************************************
  // Mode and prescale encodings
  // ****************************************
  localparam logic [1:0] MODE_FREE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDOWN = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;
  localparam logic [5:0] PRE_LIM_1   = 6'h00;
  localparam logic [5:0] PRE_LIM_4   = 6'h03;
  localparam logic [5:0] PRE_LIM_16  = 6'h0f;
  localparam logic [5:0] PRE_LIM_64  = 6'h3f;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** hw/time_base_prescaler.sv ***
// Input clock prescaler of the time base
`timescale 1ns/1ps
`default_nettype none
module time_base_prescaler (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] select,
  // Prescaled edge
  output logic            tick
);

  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] limit;

  function automatic logic [5:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_limit = pwm_time_base_pkg::PRE_LIM_1;
      2'h1:    pre_limit = pwm_time_base_pkg::PRE_LIM_4;
      2'h2:    pre_limit = pwm_time_base_pkg::PRE_LIM_16;
      default: pre_limit = pwm_time_base_pkg::PRE_LIM_64;
    endcase
  endfunction

  assign limit = pre_limit(select);
  assign tick  = (cnt == limit) && !clear;

  always_comb begin
    if (clear) begin
      next_cnt = pwm_time_base_pkg::PRE_RESET; // RULE2
    end else if (cnt == limit) begin
      next_cnt = pwm_time_base_pkg::PRE_RESET; // RULE1
    end else begin
      next_cnt = cnt + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= pwm_time_base_pkg::PRE_RESET; // RULE2
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule // time_base_prescaler
`default_nettype wire

// *** hw/pwm_time_base_output_control.sv ***
// Pulse generator time base, period buffering and output pin control
// Behaviour
// RULE1: Prescale instruction clock by 1, 4, 16, 64
// RULE2: Count or control write clears prescaler
// RULE3: Control write keeps the count value
// RULE4: Period match when count equals active period
// RULE5: Zero detect when count field is zero
// RULE6: Count bit 15 reads direction, read-only
// RULE7: Control bit 15 enables counting, keeps count
// RULE8: Postscaler 1:1 to 1:16 gates events
// RULE9: Count or control write clears postscaler
// RULE10: After match, wrap to zero or reverse
// RULE11: Period buffer loads at wrap or zero
// RULE12: Disabled time base copies period buffer through
// RULE13: Free running: postscaled event at wrap
// RULE14: Single event: event, clear enable, no postscale
// RULE15: Up/down: postscaled event leaving zero upward
// RULE16: Double update: events at zero and match
// RULE17: Mode field selects mode; events set flag
// RULE18: Modes 00 free, 01 single, 10, 11
// RULE19: Eight enable bits hand pins to module
// RULE20: Side polarity bits: 1 high, 0 low
// RULE21: Reset owner bit chooses all or no enables
// RULE22: Up/down counts down to zero, then up
// RULE23: Enabled count steps one per tick only
// RULE24: Enabled pin shows state through side polarity
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_time_base_output_control #(
  parameter logic [2:0] CONFIG_WORD = pwm_time_base_pkg::CONFIG_RESET
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  // AXI4-Lite write response
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  // AXI4-Lite read
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  // Pin states from duty logic and general port
  input  wire logic [7:0] pin_active,
  input  wire logic [7:0] port_data,
  input  wire logic [7:0] port_drive_en,
  // Pins
  output logic [3:0]      high_side_output,
  output logic [3:0]      high_side_oe,
  output logic [3:0]      low_side_output,
  output logic [3:0]      low_side_oe,
  // Status
  output logic            module_interrupt_flag
);

  // ****************************************
  // Declarations
  // ****************************************
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_fire, ctl_wr, cnt_wr, per_wr, pin_wr, sts_wr;

  logic        time_base_enable, next_time_base_enable;
  logic [3:0]  output_postscale_select, next_output_postscale_select;
  logic [1:0]  input_prescale_select, next_input_prescale_select;
  logic [1:0]  time_base_mode_select, next_time_base_mode_select;
  logic [14:0] count_value_field, next_count_value_field;
  logic        count_direction_flag, next_count_direction_flag;
  logic [14:0] time_base_period_buffer, next_time_base_period_buffer;
  logic [14:0] active_period, next_active_period;
  logic [7:0]  pulse_control_one, next_pulse_control_one;
  logic [3:0]  post_cnt, next_post_cnt;
  logic        next_module_interrupt_flag;
  logic [7:0]  pin_out, next_pin_out, pin_oe, next_pin_oe;
  logic [15:0] ctl_merged, cnt_merged, per_merged, pin_merged;
  logic        tick, period_match, zero_detect, scaled_event, direct_event;
  logic        irq_event, up_down;
  logic [7:0]  polarity;
  logic [15:0] control_view;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign ctl_wr  = wr_fire && (aw_addr == pwm_time_base_pkg::OFS_CONTROL);
  assign cnt_wr  = wr_fire && (aw_addr == pwm_time_base_pkg::OFS_COUNT);
  assign per_wr  = wr_fire && (aw_addr == pwm_time_base_pkg::OFS_PERIOD);
  assign pin_wr  = wr_fire && (aw_addr == pwm_time_base_pkg::OFS_PIN_CTRL);
  assign sts_wr  = wr_fire && (aw_addr == pwm_time_base_pkg::OFS_STATUS);
  assign control_view = {time_base_enable, 7'h00, output_postscale_select,
                         input_prescale_select, time_base_mode_select};

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (ctl_wr || cnt_wr || per_wr || pin_wr || sts_wr
          || aw_addr == pwm_time_base_pkg::OFS_CONFIG) begin
        next_bresp = pwm_time_base_pkg::RESP_OKAY;
      end else begin
        next_bresp = pwm_time_base_pkg::RESP_SLVERR;
      end
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = pwm_time_base_pkg::RESP_OKAY;
      if (araddr == pwm_time_base_pkg::OFS_CONTROL) begin
        next_rdata = {16'h0000, control_view};
      end else if (araddr == pwm_time_base_pkg::OFS_COUNT) begin
        next_rdata = {16'h0000, count_direction_flag, count_value_field}; // RULE6
      end else if (araddr == pwm_time_base_pkg::OFS_PERIOD) begin
        next_rdata = {17'h00000, time_base_period_buffer};
      end else if (araddr == pwm_time_base_pkg::OFS_PIN_CTRL) begin
        next_rdata = {24'h000000, pulse_control_one};
      end else if (araddr == pwm_time_base_pkg::OFS_STATUS) begin
        next_rdata = {31'h00000000, module_interrupt_flag};
      end else if (araddr == pwm_time_base_pkg::OFS_CONFIG) begin
        next_rdata = {29'h00000000, CONFIG_WORD};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = pwm_time_base_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= pwm_time_base_pkg::RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= pwm_time_base_pkg::RESP_OKAY;
      rdata   <= 32'h00000000;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // ****************************************
  // Time base
  // ****************************************
  time_base_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (ctl_wr || cnt_wr), // RULE2
    .select  (input_prescale_select),
    .tick    (tick)
  );

  assign period_match = (count_value_field == active_period); // RULE4
  assign zero_detect  = (count_value_field == 15'h0000); // RULE5
  assign up_down      = time_base_mode_select[1];
  assign ctl_merged   = merge16(control_view, w_data, w_strb);
  assign cnt_merged   = merge16({count_direction_flag, count_value_field}, w_data, w_strb);
  assign per_merged   = merge16({1'b0, time_base_period_buffer}, w_data, w_strb);
  assign pin_merged   = merge16({8'h00, pulse_control_one}, w_data, w_strb);

  always_comb begin
    next_time_base_enable        = time_base_enable;
    next_output_postscale_select = output_postscale_select;
    next_input_prescale_select   = input_prescale_select;
    next_time_base_mode_select   = time_base_mode_select;
    next_count_value_field       = count_value_field;
    next_count_direction_flag    = count_direction_flag;
    next_time_base_period_buffer = time_base_period_buffer;
    next_active_period           = active_period;
    next_pulse_control_one       = pulse_control_one;
    next_post_cnt                = post_cnt;
    scaled_event                 = 1'b0;
    direct_event                 = 1'b0;
    irq_event                    = 1'b0;
    if (!time_base_enable) begin
      next_active_period = time_base_period_buffer; // RULE12
    end else if (tick) begin // RULE23
      case (time_base_mode_select) // RULE17 RULE18
        pwm_time_base_pkg::MODE_FREE, pwm_time_base_pkg::MODE_SINGLE: begin
          next_count_direction_flag = 1'b0;
          if (period_match) begin
            next_count_value_field = 15'h0000; // RULE10
            next_active_period     = time_base_period_buffer; // RULE11
            if (time_base_mode_select == pwm_time_base_pkg::MODE_SINGLE) begin
              direct_event          = 1'b1; // RULE14
              next_time_base_enable = 1'b0;
            end else begin
              scaled_event = 1'b1; // RULE13
            end
          end else begin
            next_count_value_field = count_value_field + 15'h0001;
          end
        end
        default: begin
          if (zero_detect) begin
            next_active_period = time_base_period_buffer; // RULE11
          end
          if (count_direction_flag && zero_detect) begin
            next_count_direction_flag = 1'b0; // RULE22
            next_count_value_field    = 15'h0001;
            if (time_base_mode_select == pwm_time_base_pkg::MODE_DOUBLE) begin
              direct_event = 1'b1; // RULE16
            end else begin
              scaled_event = 1'b1; // RULE15
            end
          end else if (!count_direction_flag && period_match) begin
            next_count_direction_flag = !zero_detect; // RULE10
            next_count_value_field    = zero_detect ? count_value_field
                                                    : count_value_field - 15'h0001;
            direct_event = (time_base_mode_select == pwm_time_base_pkg::MODE_DOUBLE); // RULE16
          end else if (count_direction_flag) begin
            next_count_value_field = count_value_field - 15'h0001; // RULE22
          end else begin
            next_count_value_field = count_value_field + 15'h0001;
          end
        end
      endcase
    end
    if (scaled_event) begin
      if (post_cnt == output_postscale_select) begin
        next_post_cnt = pwm_time_base_pkg::POST_RESET; // RULE8
        irq_event     = 1'b1;
      end else begin
        next_post_cnt = post_cnt + 4'h1;
      end
    end
    if (direct_event) begin
      irq_event = 1'b1;
    end
    if (ctl_wr || cnt_wr) begin
      next_post_cnt = pwm_time_base_pkg::POST_RESET; // RULE9
    end
    if (ctl_wr) begin // RULE3
      next_time_base_enable        = ctl_merged[pwm_time_base_pkg::CTL_ENABLE_BIT]; // RULE7
      next_output_postscale_select = ctl_merged[pwm_time_base_pkg::CTL_OPS_LSB +: 4];
      next_input_prescale_select   = ctl_merged[pwm_time_base_pkg::CTL_CKPS_LSB +: 2];
      next_time_base_mode_select   = ctl_merged[pwm_time_base_pkg::CTL_MODE_LSB +: 2];
    end
    if (cnt_wr) begin
      next_count_value_field = cnt_merged[14:0];
    end
    if (per_wr) begin
      next_time_base_period_buffer = per_merged[14:0];
    end
    if (pin_wr) begin
      next_pulse_control_one = pin_merged[7:0]; // RULE19
    end
    // Hardware set wins over software clear
    next_module_interrupt_flag = (module_interrupt_flag
                                  && !(sts_wr && w_strb[0]
                                       && w_data[pwm_time_base_pkg::STATUS_IRQ_BIT]))
                                 || irq_event; // RULE17
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base_enable        <=
        pwm_time_base_pkg::CONTROL_RESET[pwm_time_base_pkg::CTL_ENABLE_BIT];
      output_postscale_select <=
        pwm_time_base_pkg::CONTROL_RESET[pwm_time_base_pkg::CTL_OPS_LSB +: 4];
      input_prescale_select   <=
        pwm_time_base_pkg::CONTROL_RESET[pwm_time_base_pkg::CTL_CKPS_LSB +: 2];
      time_base_mode_select   <=
        pwm_time_base_pkg::CONTROL_RESET[pwm_time_base_pkg::CTL_MODE_LSB +: 2];
      count_value_field       <= pwm_time_base_pkg::COUNT_RESET;
      count_direction_flag    <= 1'b0;
      time_base_period_buffer <= pwm_time_base_pkg::PERIOD_RESET;
      active_period           <= pwm_time_base_pkg::PERIOD_RESET;
      post_cnt                <= pwm_time_base_pkg::POST_RESET; // RULE9
      module_interrupt_flag   <= 1'b0;
      pulse_control_one       <= CONFIG_WORD[pwm_time_base_pkg::CFG_OWNER_BIT]
                                 ? pwm_time_base_pkg::PIN_EN_NONE
                                 : pwm_time_base_pkg::PIN_EN_ALL; // RULE21
    end else begin
      time_base_enable        <= next_time_base_enable;
      output_postscale_select <= next_output_postscale_select;
      input_prescale_select   <= next_input_prescale_select;
      time_base_mode_select   <= next_time_base_mode_select;
      count_value_field       <= next_count_value_field;
      count_direction_flag    <= next_count_direction_flag;
      time_base_period_buffer <= next_time_base_period_buffer;
      active_period           <= next_active_period;
      post_cnt                <= next_post_cnt;
      module_interrupt_flag   <= next_module_interrupt_flag;
      pulse_control_one       <= next_pulse_control_one;
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  assign polarity = {{4{CONFIG_WORD[pwm_time_base_pkg::CFG_HIGH_SIDE_POLARITY_BIT]}},
                     {4{CONFIG_WORD[pwm_time_base_pkg::CFG_LOW_SIDE_POLARITY_BIT]}}}; // RULE20

  always_comb begin
    next_pin_out = (pulse_control_one & (pin_active ~^ polarity))
                   | (~pulse_control_one & port_data); // RULE24
    next_pin_oe  = pulse_control_one | port_drive_en; // RULE19
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  assign low_side_output  = pin_out[3:0];
  assign low_side_oe      = pin_oe[3:0];
  assign high_side_output = pin_out[7:4];
  assign high_side_oe     = pin_oe[7:4];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence top_turn_s;
    time_base_enable && tick && up_down && !count_direction_flag
      && period_match && !zero_detect && !ctl_wr && !cnt_wr;
  endsequence

  sequence falling_s;
    count_direction_flag && count_value_field == $past(active_period) - 15'h0001;
  endsequence

  prescale_sixtyfour_a: assert property ( // RULE1
    tick && input_prescale_select == 2'h3 && !ctl_wr |=> !tick [*8])
    else $error("prescale 64 ticked too early");

  count_hold_a: assert property ( // RULE7
    !time_base_enable && !cnt_wr |=> $stable(count_value_field))
    else $error("count moved while disabled");

  count_step_a: assert property ( // RULE23
    time_base_enable && tick && !period_match && !up_down && !cnt_wr
    |=> count_value_field == $past(count_value_field) + 15'h0001)
    else $error("count did not step by one");

  free_wrap_a: assert property ( // RULE10
    time_base_enable && tick && period_match && !up_down && !cnt_wr
    |=> count_value_field == 15'h0000)
    else $error("no wrap after match");

  single_stop_a: assert property ( // RULE14
    time_base_enable && tick && period_match && !ctl_wr
    && time_base_mode_select == pwm_time_base_pkg::MODE_SINGLE
    |=> !time_base_enable && module_interrupt_flag)
    else $error("single event did not stop");

  period_copy_a: assert property ( // RULE12
    !time_base_enable |=> active_period == $past(time_base_period_buffer))
    else $error("period not copied while disabled");

  top_reverse_a: assert property ( // RULE22
    top_turn_s |=> falling_s)
    else $error("no reversal at period match");

  flag_set_a: assert property ( // RULE17
    irq_event |=> module_interrupt_flag)
    else $error("event did not set flag");

  pin_drive_a: assert property ( // RULE24
    pulse_control_one[0] && $stable(pulse_control_one)
    |=> low_side_oe[0] && low_side_output[0] == ($past(pin_active[0])
        ~^ CONFIG_WORD[pwm_time_base_pkg::CFG_LOW_SIDE_POLARITY_BIT]))
    else $error("enabled pin drive wrong");

endmodule // pwm_time_base_output_control
`default_nettype wire

// *** sim/gate_driver_model.sv ***
// Gate driver stage seen at the pulse output pins
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
  // Pins from the block
  input  wire logic [3:0] high_side_output,
  input  wire logic [3:0] high_side_oe,
  input  wire logic [3:0] low_side_output,
  input  wire logic [3:0] low_side_oe,
  // Gate levels, bit 7:4 high side
  output logic [7:0]      gate
);
  // Undriven gate inputs sit on their pull-down
  assign gate = {high_side_output & high_side_oe, low_side_output & low_side_oe};
endmodule // gate_driver_model
`default_nettype wire

// *** sim/tb_pwm_time_base_output_control.sv ***
// Self-checking testbench of the pulse time base and pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_time_base_output_control;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        module_interrupt_flag;
  logic [7:0]  awaddr = '0, araddr = '0, pin_active = '0, port_data = '0, port_drive_en = '0;
  logic [31:0] wdata = '0, rdata, rd, ctl[4], n;
  logic [3:0]  wstrb = 4'hf, high_side_output, high_side_oe, low_side_output, low_side_oe;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  gate, en;
  int          num_errors = 0, num_checks = 0, lo[4], hi[4];
  always #4 aclk = ~aclk;
  pwm_time_base_output_control #(.CONFIG_WORD(3'h4)) dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pin_active, .port_data, .port_drive_en,
    .high_side_output, .high_side_oe, .low_side_output, .low_side_oe, .module_interrupt_flag);
  gate_driver_model drv (.high_side_output, .high_side_oe, .low_side_output, .low_side_oe, .gate);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      #1 ta = awready;
      tw = wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    logic ta, t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      #1 ta = arready;
      t = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // Pins at polarity 0: enabled pins show the inverse of the active state
  function logic [31:0] pin_exp(input logic [7:0] e, a, pd, pe);
    return {24'h0, (e & ~a) | (~e & pd & pe)};
  endfunction
  initial begin
    void'($urandom(32'he8ec4847));
    ctl = '{32'h8000, 32'h8030, 32'h8004, 32'h8008};
    lo = '{0, 5, 5, 28};
    hi = '{4, 12, 12, 40};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h0c);
    chk(rd, 32'h0);
    rdr(8'h14);
    chk(rd, 32'h4);
    rdr(8'h18);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h18, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h04, 32'h8003);
    rdr(8'h04);
    chk(rd, 32'h3);
    wr(8'h00, 32'h0020);
    rdr(8'h04);
    chk(rd, 32'h3);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h10, 32'h1);
      wr(8'h08, 32'h1);
      wr(8'h00, ctl[i]);
      n = 0;
      #1;
      while (module_interrupt_flag !== 1'b1 && n < 60) begin
        @(posedge aclk);
        #1 n++;
      end
      chk({31'h0, n >= lo[i] && n <= hi[i]}, 32'h1);
    end
    $display("scaler test done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h1);
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h8001);
    repeat (20) @(posedge aclk);
    rdr(8'h00);
    chk(rd, 32'h1);
    rdr(8'h04);
    chk(rd, 32'h0);
    rdr(8'h10);
    chk(rd, 32'h1);
    for (int m = 2; m < 4; m++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h4);
      wr(8'h00, 32'h8000 | m);
      repeat ($urandom_range(40, 5)) @(posedge aclk);
      wr(8'h00, m);
      rdr(8'h04);
      n = rd;
      repeat (10) @(posedge aclk);
      rdr(8'h04);
      chk(rd, n);
      chk({31'h0, rd[14:0] <= 15'h4}, 32'h1);
    end
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h800e);
    repeat (350) @(posedge aclk);
    rdr(8'h04);
    chk(rd, 32'h8003);
    wr(8'h00, 32'h0);
    $display("mode test done");
    for (int i = 0; i < 8; i++) begin
      en = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      wr(8'h0c, {24'h0, en});
      pin_active <= 8'($urandom);
      port_data <= 8'($urandom);
      port_drive_en <= 8'($urandom);
      repeat (3) @(posedge aclk);
      #1;
      chk({24'h0, gate}, pin_exp(en, pin_active, port_data, port_drive_en));
    end
    $display("pin test done");
    end_sim;
  end
  initial begin
    #400000;
    num_errors++;
    end_sim;
  end
endmodule // tb_pwm_time_base_output_control
`default_nettype wire
